// file: logic/output_trigger_and_module_sync.sv
`timescale 1ns/1ps
module output_trigger_and_module_sync
  import trig_sync_pkg::*;
#(
  parameter int SAMPLE_WIDTH = SAMPLE_W,
  parameter int DIV_WIDTH    = RATE_W
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire syncMode_e               syncMode,
  input  wire logic                    syncModeWrite,
  input  wire logic                    appExit,
  input  wire trigSrc_e                trigSource,
  input  wire refSrc_e                 refSource,
  input  wire logic                    singleTrigPeer,
  input  wire logic [DIV_WIDTH-1:0]    rateDiv,
  input  wire logic                    arm,
  input  wire logic                    startCmd,
  input  wire logic                    stopCmd,
  input  wire logic                    extTrig,
  input  wire logic                    thresholdHit,
  input  wire logic                    linkTrigIn,
  input  wire logic                    linkClkIn,
  input  wire logic [SAMPLE_WIDTH-1:0] sampleData,
  input  wire logic                    sampleValid,
  output logic                         sampleReady,
  output logic [SAMPLE_WIDTH-1:0]      dacCode,
  output logic                         dacStrobe,
  output logic                         running,
  output logic                         waiting,
  output logic                         underrunEvent,
  output logic                         refTrigEvent,
  output logic                         linkTrigOut,
  output logic                         linkTrigOe,
  output logic                         linkClkOut,
  output logic                         linkClkOe,
  output syncMode_e                    activeMode
);

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} run_e;

  run_e                    state_q;
  run_e                    state_d;
  syncMode_e               mode_q;
  syncMode_e               mode_d;
  logic [1:0]              extSync_q;
  logic [1:0]              linkSync_q;
  logic [1:0]              linkClkSync_q;
  logic                    extPrev_q;
  logic                    linkPrev_q;
  logic                    linkClkPrev_q;
  logic [DIV_WIDTH-1:0]    divCnt_q;
  logic [DIV_WIDTH-1:0]    divCnt_d;
  logic [SAMPLE_WIDTH-1:0] code_q;
  logic                    strobe_q;
  logic                    underrun_q;
  logic                    trigPulse_q;
  logic                    refEvt_q;
  logic                    clkOut_q;

  // ----------------------------------------------------------------
  // state decode
  // ----------------------------------------------------------------
  wire inIdle  = (state_q == ST_IDLE);
  wire inArmed = (state_q == ST_ARMED);
  wire inRun   = (state_q == ST_RUN);

  // ----------------------------------------------------------------
  // sync mode register
  // ----------------------------------------------------------------
  // mode only moves on an explicit write or an exit; exit wins over a write
  always_comb begin
    mode_d = mode_q;
    if (appExit) begin
      mode_d = SYNC_NONE;
    end else if (syncModeWrite) begin
      mode_d = syncMode;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= SYNC_NONE;
    end else begin
      mode_q <= mode_d;
    end
  end

  wire isMaster = (mode_q == SYNC_MASTER);
  wire isSlave  = (mode_q == SYNC_SLAVE);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // first stage feeds only the second; edges looked at on stage two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extSync_q <= 2'h0;
      extPrev_q <= 1'b0;
    end else begin
      extSync_q <= {extSync_q[0], extTrig};
      extPrev_q <= extSync_q[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkSync_q <= 2'h0;
      linkPrev_q <= 1'b0;
    end else begin
      linkSync_q <= {linkSync_q[0], linkTrigIn};
      linkPrev_q <= linkSync_q[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkClkSync_q <= 2'h0;
      linkClkPrev_q <= 1'b0;
    end else begin
      linkClkSync_q <= {linkClkSync_q[0], linkClkIn};
      linkClkPrev_q <= linkClkSync_q[1];
    end
  end

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  // one delayed copy per pin, so each pin edge gives a single cycle
  wire extRise     = extSync_q[1] & ~extPrev_q;
  wire extFall     = ~extSync_q[1] & extPrev_q;
  wire linkRise    = linkSync_q[1] & ~linkPrev_q;
  wire linkClkRise = linkClkSync_q[1] & ~linkClkPrev_q;

  // ----------------------------------------------------------------
  // start trigger selection
  // ----------------------------------------------------------------
  wire srcSoftware = (trigSource == SRC_SOFTWARE);
  wire srcExtPos   = (trigSource == SRC_EXT_POS);
  wire srcExtNeg   = (trigSource == SRC_EXT_NEG);
  wire extEdge     = (srcExtPos & extRise) | (srcExtNeg & extFall);
  wire swStart     = srcSoftware & startCmd;
  wire localStart  = swStart | extEdge;
  // slave listens to the link alone; local sources are dropped
  wire startTrig   = isSlave ? linkRise : localStart;
  // a slave armed after the link trigger never sees a start
  wire doStart     = inArmed & startTrig;

  // ----------------------------------------------------------------
  // reference trigger selection
  // ----------------------------------------------------------------
  wire refSelExt    = (refSource == REF_EXT);
  wire refSelThresh = (refSource == REF_THRESH);
  wire refSelLink   = (refSource == REF_LINK);
  // a single-trigger peer spends its one link pulse on the start
  wire refLinkOk    = ~(isSlave & singleTrigPeer);
  wire refExtHit    = refSelExt & extRise;
  wire refThrHit    = refSelThresh & thresholdHit;
  wire refLinkHit   = refSelLink & linkRise & refLinkOk;
  wire refHit       = refExtHit | refThrHit | refLinkHit;

  // ----------------------------------------------------------------
  // sample tick
  // ----------------------------------------------------------------
  // local divider from the internal reference, independent per module
  wire divDone    = (divCnt_q == '0);
  wire localTick  = inRun & divDone;
  wire slaveTick  = inRun & linkClkRise;
  // slave paces on the master's clock, none and master on the local one
  wire sampleTick = isSlave ? slaveTick : localTick;

  always_comb begin
    divCnt_d = divCnt_q - 1'b1;
    if (!inRun || divDone) begin
      divCnt_d = rateDiv;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_d;
    end
  end

  // ----------------------------------------------------------------
  // run state machine
  // ----------------------------------------------------------------
  // stop is local only; a master stopping sends nothing to the slaves
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (arm) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (stopCmd) begin
          state_d = ST_IDLE;
        end else if (doStart) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stopCmd) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------
  // code passes through untouched; offset binary midscale at reset
  wire takeSample = sampleTick & sampleValid;
  wire starved    = sampleTick & ~sampleValid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= SAMPLE_RST;
    end else if (takeSample) begin
      code_q <= sampleData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= takeSample;
    end
  end

  // a tick with nothing offered is a lost sample, not a stall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      underrun_q <= 1'b0;
    end else begin
      underrun_q <= starved;
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  // master pulses its start once per start and its sample clock once per tick
  wire masterStart = isMaster & doStart;
  wire masterTick  = isMaster & localTick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigPulse_q <= 1'b0;
    end else begin
      trigPulse_q <= masterStart;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkOut_q <= 1'b0;
    end else begin
      clkOut_q <= masterTick;
    end
  end

  // reference events only count while the run is live
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refEvt_q <= 1'b0;
    end else begin
      refEvt_q <= inRun & refHit;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // link outputs gated by mode so a mode change cuts them at once
  assign sampleReady   = sampleTick;
  assign dacCode       = code_q;
  assign dacStrobe     = strobe_q;
  assign running       = inRun;
  assign waiting       = inArmed & ~inIdle;
  assign underrunEvent = underrun_q;
  assign refTrigEvent  = refEvt_q;
  assign linkTrigOut   = trigPulse_q & isMaster;
  assign linkTrigOe    = isMaster;
  assign linkClkOut    = clkOut_q & isMaster;
  assign linkClkOe     = isMaster;
  assign activeMode    = mode_q;

endmodule // output_trigger_and_module_sync

// file: logic/trig_sync_pkg.sv
// Notes on behaviour
// - software source: a host start command begins output conversions at once.
// - external source: start on chosen rising or falling edge of external trigger.
// - slave takes trigger and sample clock from link, ignores external trigger as a start.
// - slave: link trigger is the only start trigger, other sources ignored.
// - samples are offset binary; zeros negative full scale, ones positive.
// - converter running out of host samples while running raises underrun event.
// - master drives its start trigger and sample clock onto the link.
// - default mode none: local clock, link not driven; link used only as a reference trigger source.
// - programmed sync mode holds until software changes it or application exits.
// - master and armed slaves start within one conversion period; here a slave starts three clocks after the master.
// - stopping master does not stop slaves; each stops on its own command.
// - each module's sample rate is programmed independently.
// - slave to single-trigger peer: reference trigger is external or threshold only.
// - local sample timing comes from the shared internal reference clock.
package trig_sync_pkg;

  // ----------------------------------------------------------------
  // modes and sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SYNC_NONE, SYNC_MASTER, SYNC_SLAVE} syncMode_e;
  typedef enum logic [1:0] {SRC_SOFTWARE, SRC_EXT_POS, SRC_EXT_NEG} trigSrc_e;
  typedef enum logic [1:0] {REF_NONE, REF_EXT, REF_THRESH, REF_LINK} refSrc_e;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int        SAMPLE_W     = 32;
  localparam int        RATE_W       = 16;
  localparam logic [15:0] RATE_DIV_RST = 16'h00de;
  localparam logic [31:0] SAMPLE_RST   = 32'h80000000;

endpackage

// file: verif/output_trigger_and_module_sync_assertions.sv
`timescale 1ns/1ps
module output_trigger_and_module_sync_assertions
  import trig_sync_pkg::*;
#(
  parameter int SAMPLE_WIDTH = SAMPLE_W
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    syncModeWrite,
  input wire logic                    appExit,
  input wire trigSrc_e                trigSource,
  input wire logic                    startCmd,
  input wire logic                    stopCmd,
  input wire logic                    linkTrigIn,
  input wire logic [SAMPLE_WIDTH-1:0] sampleData,
  input wire logic                    sampleValid,
  input wire logic                    sampleReady,
  input wire logic [SAMPLE_WIDTH-1:0] dacCode,
  input wire logic                    dacStrobe,
  input wire logic                    running,
  input wire logic                    waiting,
  input wire logic                    underrunEvent,
  input wire logic                    linkTrigOut,
  input wire logic                    linkTrigOe,
  input wire logic                    linkClkOut,
  input wire logic                    linkClkOe,
  input wire syncMode_e               activeMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence swGo;
    waiting && startCmd && !stopCmd && activeMode != SYNC_SLAVE && trigSource == SRC_SOFTWARE;
  endsequence
  // eight quiet cycles covers the full sync and edge pipeline
  sequence slaveQuiet;
    (activeMode == SYNC_SLAVE && waiting && !linkTrigIn) [*8];
  endsequence
  a_sw_start: assert property (swGo |=> running)
    else $error("software start missed");
  a_slave_deaf: assert property (slaveQuiet |=> !running)
    else $error("slave started without link trigger");
  a_oe_master: assert property (linkTrigOe == (activeMode == SYNC_MASTER) && linkClkOe == linkTrigOe)
    else $error("link drive enable wrong");
  a_none_quiet: assert property (activeMode == SYNC_NONE |-> !linkTrigOut && !linkClkOut)
    else $error("link driven in mode none");
  a_mode_hold: assert property (!syncModeWrite && !appExit |=> $stable(activeMode))
    else $error("mode changed on its own");
  a_exit_none: assert property (appExit |=> activeMode == SYNC_NONE)
    else $error("exit did not clear mode");
  a_sample_pass: assert property (sampleReady && sampleValid |=> dacStrobe && dacCode == $past(sampleData))
    else $error("sample not passed unchanged");
  a_underrun_cause: assert property (underrunEvent |-> $past(running) && !$past(sampleValid))
    else $error("underrun without cause");
  a_run_hold: assert property (running && !stopCmd |=> running)
    else $error("run ended without its own stop");
endmodule // output_trigger_and_module_sync_assertions

bind output_trigger_and_module_sync output_trigger_and_module_sync_assertions
  #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) i_output_trigger_and_module_sync_assertions (
  .clk, .rst_n, .syncModeWrite, .appExit, .trigSource, .startCmd, .stopCmd,
  .linkTrigIn, .sampleData, .sampleValid, .sampleReady, .dacCode, .dacStrobe,
  .running, .waiting, .underrunEvent, .linkTrigOut, .linkTrigOe, .linkClkOut,
  .linkClkOe, .activeMode);

// file: verif/sync_peer_model.sv
`timescale 1ns/1ps
module sync_peer_model (
  input  wire logic run,
  output logic      linkTrig,
  output logic      linkClk
);
  initial begin
    linkTrig = 1'b0;
    linkClk  = 1'b0;
  end
  // held over several of our periods so the two-stage sync cannot miss it
  always @(posedge run) begin
    #13 linkTrig = 1'b1;
    #40 linkTrig = 1'b0;
  end
  // link clock stands still while the peer is not running
  always begin
    wait (run);
    #18.5 linkClk = ~linkClk;
  end
endmodule // sync_peer_model

// file: verif/output_trigger_and_module_sync_tb_top.sv
`timescale 1ns/1ps
module output_trigger_and_module_sync_tb_top;
  import trig_sync_pkg::*;
  logic clk = 0, rst_n = 0, syncModeWrite = 0, appExit = 0, arm = 0, startCmd = 0, stopCmd = 0;
  logic extTrig = 0, sampleValid = 0, peerRun = 0, linkTrigIn, linkClkIn, sampleReady, dacStrobe;
  logic running, waiting, underrunEvent, refTrigEvent, linkTrigOut, linkTrigOe, linkClkOut, linkClkOe;
  logic [31:0] sampleData = 0, dacCode, seed = 32'h0000004e;
  logic [15:0] rateDiv = 0;
  syncMode_e   syncMode = SYNC_NONE, activeMode;
  trigSrc_e    trigSource = SRC_SOFTWARE;
  refSrc_e     refSource = REF_NONE;
  logic        singleTrigPeer = 0, thresholdHit = 0, refSeen = 0;
  int          errCount = 0, cmpCount = 0;
  always #5 clk = ~clk;
  output_trigger_and_module_sync i_output_trigger_and_module_sync (
    .clk, .rst_n, .syncMode, .syncModeWrite, .appExit, .trigSource, .refSource,
    .singleTrigPeer, .rateDiv, .arm, .startCmd, .stopCmd, .extTrig, .thresholdHit,
    .linkTrigIn, .linkClkIn, .sampleData, .sampleValid, .sampleReady, .dacCode, .dacStrobe,
    .running, .waiting, .underrunEvent, .refTrigEvent, .linkTrigOut, .linkTrigOe, .linkClkOut,
    .linkClkOe, .activeMode);
  sync_peer_model i_sync_peer_model (.run(peerRun), .linkTrig(linkTrigIn), .linkClk(linkClkIn));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask
  // valid held until taken; caller drops it after the last word
  task automatic feed(input logic [31:0] d);
    sampleData = d;
    sampleValid = 1'b1;
    repeat (60) if (sampleReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    #1 chk(dacStrobe, 1'b1);
    chk(dacCode, d);
  endtask
  task automatic completeRun();
    $display("errors %0d compares %0d", errCount, cmpCount);
    if (errCount == 0 && cmpCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(dacCode, SAMPLE_RST);
    chk(activeMode, SYNC_NONE);
    syncMode = SYNC_MASTER;
    rateDiv = 16'(xs() & 32'h00000003);
    pulse(syncModeWrite);
    chk(linkTrigOe, 1'b1);
    pulse(arm);
    pulse(startCmd);
    chk(running, 1'b1);
    repeat (4) if (linkTrigOut !== 1'b1) @(negedge clk);
    chk(linkTrigOut, 1'b1);
    for (int i = 0; i < 6; i++) feed(i == 0 ? 32'h00000000 : i == 1 ? 32'hffffffff : xs());
    sampleValid = 1'b0;
    repeat (40) if (underrunEvent !== 1'b1) @(negedge clk);
    chk(underrunEvent, 1'b1);
    pulse(stopCmd);
    pulse(appExit);
    chk(activeMode, SYNC_NONE);
    for (int i = 0; i < 2; i++) begin
      trigSource = i ? SRC_EXT_NEG : SRC_EXT_POS;
      extTrig = !i;
      // idle level must clear the synchroniser before arming
      repeat (4) @(posedge clk);
      pulse(arm);
      #1 extTrig = i;
      repeat (8) @(posedge clk);
      chk(running, 1'b0);
      #1 extTrig = !i;
      repeat (8) if (running !== 1'b1) @(negedge clk);
      chk(running, 1'b1);
      pulse(stopCmd);
    end
    syncMode = SYNC_SLAVE;
    trigSource = SRC_SOFTWARE;
    pulse(syncModeWrite);
    pulse(arm);
    pulse(startCmd);
    extTrig = 1'b0;
    repeat (8) @(posedge clk);
    chk(running, 1'b0);
    #1 peerRun = 1'b1;
    repeat (12) if (running !== 1'b1) @(negedge clk);
    chk(running, 1'b1);
    for (int i = 0; i < 3; i++) feed(xs());
    sampleValid = 1'b0;
    refSource = REF_LINK;
    singleTrigPeer = 1'b1;
    peerRun = 1'b0;
    repeat (20) @(posedge clk);
    chk(running, 1'b1);
    #1 peerRun = 1'b1;
    refSeen = 1'b0;
    repeat (12) begin
      @(negedge clk);
      refSeen |= refTrigEvent;
    end
    chk(refSeen, 1'b0);
    refSource = REF_THRESH;
    pulse(thresholdHit);
    chk(refTrigEvent, 1'b1);
    refSource = REF_EXT;
    #1 extTrig = 1'b1;
    repeat (8) if (refTrigEvent !== 1'b1) @(negedge clk);
    chk(refTrigEvent, 1'b1);
    pulse(stopCmd);
    chk(running, 1'b0);
    completeRun();
  end
  // whole run is under two hundred cycles
  initial begin
    #100000 errCount++;
    completeRun();
  end
endmodule // output_trigger_and_module_sync_tb_top
